// *** rtl/dfu_fault_unit.sv ***
/*
 * Data access fault unit: checks each data access of the core, takes the data
 * fault or the translation miss, reports data fault cause and address, gates side effects.
 * Assumes one request per acc_valid pulse from the load/store unit, with page
 * attributes valid in that cycle, and a plain register port on clk_sys.
 */
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "dfu_consts.svh"
module dfu_fault_unit #(
    parameter int PAGE_BITS = 12
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic acc_valid,
    input wire dfu_pkg::dfu_req_t acc_req,
    input wire dfu_pkg::dfu_page_t page_first,
    input wire dfu_pkg::dfu_page_t page_second,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic dsi_take,
    output logic miss_take,
    output logic [31:0] vec_addr,
    output logic [1:0] page_access,
    output logic [1:0] regs_wb,
    output logic resv_check,
    output logic base_update,
    output logic irq
);
    logic [31:0] syndrome_q;
    logic [31:0] fault_addr_q;
    logic prefix_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;

    logic is_store;
    logic is_load;
    logic elig_op;
    logic elig;
    logic p0_prot, p0_ds, p0_miss;
    logic p1_prot, p1_ds, p1_miss;
    logic f0_dsi, f1_dsi, miss0, miss1;
    logic take_dsi, take_miss, fault_second;
    logic [1:0] access_d;
    logic [31:0] syndrome_d;
    logic [31:0] fault_addr_d;
    logic [31:0] vec_base;

    always_comb begin
        is_store = (acc_req.op == dfu_pkg::DFU_OP_STORE) | (acc_req.op == dfu_pkg::DFU_OP_DC_ZERO);
        is_load = (acc_req.op == dfu_pkg::DFU_OP_LOAD);
        elig_op = (acc_req.op != dfu_pkg::DFU_OP_OTHER);
        // A zero byte count moves nothing, so no page is examined
        elig = acc_valid & elig_op & ~acc_req.str_imm_zero;
    end

    dfu_page_check #(
        .PP_W(2)
    ) u_chk_first (
        .page(page_first),
        .is_store(is_store),
        .problem_state(acc_req.problem_state),
        .used(elig),
        .prot_fault(p0_prot),
        .dstore_fault(p0_ds),
        .miss(p0_miss)
    );

    // The second page is only of interest once the first one passed
    dfu_page_check #(
        .PP_W(2)
    ) u_chk_second (
        .page(page_second),
        .is_store(is_store),
        .problem_state(acc_req.problem_state),
        .used(elig & acc_req.crosses_page & ~f0_dsi & ~miss0),
        .prot_fault(p1_prot),
        .dstore_fault(p1_ds),
        .miss(p1_miss)
    );

    always_comb begin
        f0_dsi = elig & (acc_req.mem_unsupported
                 | p0_ds | p0_prot
                 | acc_req.bus_err_dstore);
        miss0 = p0_miss & ~f0_dsi;
        // Memory into direct-store crossing shows up as a second page direct-store hit
        f1_dsi = p1_ds | p1_prot;
        miss1 = p1_miss & ~f1_dsi;
        take_dsi = f0_dsi | f1_dsi;
        take_miss = ~take_dsi & (miss0 | miss1);
        fault_second = ~f0_dsi & f1_dsi;
    end

    always_comb begin
        access_d = 2'h0;
        if (acc_valid & ~acc_req.str_imm_zero) begin
            if (!elig_op) begin
                access_d[0] = 1'b1;
                access_d[1] = acc_req.crosses_page;
            end else begin
                // A faulting page is never touched, so neither protected nor direct-store bytes move
                access_d[0] = ~f0_dsi & ~miss0;
                access_d[1] = acc_req.crosses_page & ~f0_dsi & ~miss0 & ~f1_dsi & ~miss1;
            end
        end
    end

    always_comb begin
        syndrome_d = 32'h0000_0000;
        syndrome_d[`DFU_SYN_PROT] = p0_prot | (fault_second & p1_prot);
        syndrome_d[`DFU_SYN_DSTORE] = acc_req.mem_unsupported | p0_ds | acc_req.bus_err_dstore
                                      | (fault_second & p1_ds);
        syndrome_d[`DFU_SYN_STORE] = is_store;
        if (fault_second) begin
            fault_addr_d = {acc_req.ea_second[31:PAGE_BITS], PAGE_BITS'(0)};
        end else begin
            fault_addr_d = acc_req.ea;
        end
        vec_base = prefix_q ? `DFU_VEC_HIGH_BASE : `DFU_VEC_LOW_BASE;
    end

    // Redirect and fault report land on the same edge, so the handler sees them at once
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dsi_take <= 1'b0;
            miss_take <= 1'b0;
            vec_addr <= `DFU_VEC_LOW_BASE;
        end else begin
            dsi_take <= take_dsi;
            miss_take <= take_miss;
            vec_addr <= vec_base | `DFU_VEC_OFFSET;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            page_access <= 2'h0;
            regs_wb <= 2'h0;
            resv_check <= 1'b0;
            base_update <= 1'b0;
        end else begin
            page_access <= access_d;
            // Multiple and string loads keep what the clean first page delivered
            regs_wb[0] <= is_load & access_d[0] & (~take_dsi | acc_req.multi_or_string);
            regs_wb[1] <= is_load & access_d[1];
            resv_check <= acc_valid & acc_req.cond_store & ~take_dsi & ~take_miss;
            base_update <= acc_valid & acc_req.update_form & ~take_dsi & ~take_miss;
        end
    end

    // Hardware capture wins over a software write in the same cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            syndrome_q <= `DFU_RST_SYNDROME;
            fault_addr_q <= `DFU_RST_FAULT_ADDR;
        end else if (take_dsi) begin
            syndrome_q <= syndrome_d;
            fault_addr_q <= fault_addr_d;
        end else if (reg_wr) begin
            if (reg_addr == `DFU_OFF_SYNDROME) begin
                syndrome_q <= reg_wdata;
            end else if (reg_addr == `DFU_OFF_FAULT_ADDR) begin
                fault_addr_q <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prefix_q <= `DFU_RST_PREFIX;
            irq_mask_q <= `DFU_RST_IRQ;
        end else if (reg_wr) begin
            if (reg_addr == `DFU_OFF_MACHINE_STATE) begin
                prefix_q <= reg_wdata[`DFU_MSR_PREFIX];
            end else if (reg_addr == `DFU_OFF_IRQ_MASK) begin
                irq_mask_q <= reg_wdata[1:0];
            end
        end
    end

    // Write one to clear; a new event in the same cycle keeps its bit
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_stat_q <= `DFU_RST_IRQ;
        end else begin
            if (reg_wr && reg_addr == `DFU_OFF_IRQ_STATUS) begin
                irq_stat_q <= (irq_stat_q & ~reg_wdata[1:0]) | {take_miss, take_dsi};
            end else begin
                irq_stat_q <= irq_stat_q | {take_miss, take_dsi};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else if (reg_wr && reg_addr == `DFU_OFF_IRQ_STATUS) begin
            irq <= |(((irq_stat_q & ~reg_wdata[1:0]) | {take_miss, take_dsi}) & irq_mask_q);
        end else if (reg_wr && reg_addr == `DFU_OFF_IRQ_MASK) begin
            irq <= |((irq_stat_q | {take_miss, take_dsi}) & reg_wdata[1:0]);
        end else begin
            irq <= |((irq_stat_q | {take_miss, take_dsi}) & irq_mask_q);
        end
    end

    // Unmapped offsets read as zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            if (reg_addr == `DFU_OFF_SYNDROME) begin
                reg_rdata <= syndrome_q;
            end else if (reg_addr == `DFU_OFF_FAULT_ADDR) begin
                reg_rdata <= fault_addr_q;
            end else if (reg_addr == `DFU_OFF_MACHINE_STATE) begin
                reg_rdata <= {31'h0000_0000, prefix_q};
            end else if (reg_addr == `DFU_OFF_IRQ_STATUS) begin
                reg_rdata <= {30'h0000_0000, irq_stat_q};
            end else if (reg_addr == `DFU_OFF_IRQ_MASK) begin
                reg_rdata <= {30'h0000_0000, irq_mask_q};
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Helpers for the checks below
    logic [31:0] ea_second_hi;
    logic ds_first_req;
    logic cross_into_ds;
    always_comb begin
        ea_second_hi = {acc_req.ea_second[31:PAGE_BITS], PAGE_BITS'(0)};
        ds_first_req = elig & page_first.direct_store_flag;
        cross_into_ds = elig & acc_req.crosses_page & ~page_first.direct_store_flag
                        & ~page_first.miss & page_second.direct_store_flag
                        & ~acc_req.mem_unsupported & ~acc_req.bus_err_dstore & ~p0_prot;
    end

    sequence s_second_fault;
        cross_into_ds;
    endsequence

    sequence s_report_second;
        dsi_take && syndrome_q[`DFU_SYN_DSTORE] && fault_addr_q[PAGE_BITS-1:0] < 4
            && fault_addr_q[31:PAGE_BITS] == $past(ea_second_hi[31:PAGE_BITS]);
    endsequence

    property p_vector;
        @(posedge clk_sys) disable iff (!rstn)
        dsi_take |-> vec_addr == (($past(prefix_q) ? `DFU_VEC_HIGH_BASE : `DFU_VEC_LOW_BASE) | `DFU_VEC_OFFSET);
    endproperty
    a_vector: assert property (p_vector) else $error("wrong handler vector");

    property p_dstore;
        @(posedge clk_sys) disable iff (!rstn)
        ds_first_req |=> dsi_take && !miss_take && syndrome_q[`DFU_SYN_DSTORE] && page_access == 2'h0;
    endproperty
    a_dstore: assert property (p_dstore) else $error("direct-store access not faulted");

    property p_cross;
        @(posedge clk_sys) disable iff (!rstn)
        s_second_fault |=> s_report_second;
    endproperty
    a_cross: assert property (p_cross) else $error("second page fault misreported");

    property p_miss_excl;
        @(posedge clk_sys) disable iff (!rstn)
        miss_take |-> !dsi_take && !base_update && !resv_check;
    endproperty
    a_miss_excl: assert property (p_miss_excl) else $error("miss taken together with data fault");

    property p_zero_count;
        @(posedge clk_sys) disable iff (!rstn)
        acc_valid && acc_req.str_imm_zero |=> !dsi_take && !miss_take && page_access == 2'h0;
    endproperty
    a_zero_count: assert property (p_zero_count) else $error("zero count access faulted");

    property p_op_class;
        @(posedge clk_sys) disable iff (!rstn)
        acc_valid && acc_req.op == dfu_pkg::DFU_OP_OTHER |=> !dsi_take;
    endproperty
    a_op_class: assert property (p_op_class) else $error("fault from non data operation");

    property p_resv;
        @(posedge clk_sys) disable iff (!rstn)
        dsi_take |-> !resv_check && !base_update;
    endproperty
    a_resv: assert property (p_resv) else $error("reservation or base updated on fault");

    property p_bus_err;
        @(posedge clk_sys) disable iff (!rstn)
        elig && acc_req.bus_err_dstore |=> dsi_take && syndrome_q[`DFU_SYN_DSTORE]
            && fault_addr_q == $past(acc_req.ea);
    endproperty
    a_bus_err: assert property (p_bus_err) else $error("bus error crossing not reported");

    property p_prot_nowrite;
        @(posedge clk_sys) disable iff (!rstn)
        elig && p0_prot |=> dsi_take && syndrome_q[`DFU_SYN_PROT] && page_access == 2'h0 && regs_wb == 2'h0;
    endproperty
    a_prot_nowrite: assert property (p_prot_nowrite) else $error("protected page accessed");

    property p_update;
        @(posedge clk_sys) disable iff (!rstn)
        acc_valid && acc_req.update_form && !take_dsi && !take_miss |=> base_update;
    endproperty
    a_update: assert property (p_update) else $error("clean update form lost base update");

endmodule : dfu_fault_unit
`default_nettype wire

// *** rtl/dfu_consts.svh ***
/*
 * Constants of the data access fault unit: register offsets, field positions,
 * reset values and vector figures.
 * Assumes inclusion by bare name from the fault unit and the bench.
 */
// How it works
// - Unsupported memory type for the instruction raises the data fault
// - Any access to a segment with direct_store_flag set raises the data fault
// - Key, page or block protection violations raise the data fault
// - Untranslatable address takes a translation-miss exception, not the data fault
// - Bus error on direct-store to memory crossing raises the data fault
// - One access crossing from memory into direct-store segment raises the data fault
// - Only loads, stores and four cache control operations can raise it
// - Page crossing allowed; second page fault is taken mid-instruction
// - Second page fault puts a first-word address of that page in fault_address_reg
// - Faulting conditional store skips the reservation check
// - Zero byte count immediate string access never raises the data fault
// - Handler fetch starts at offset 0x300 from base chosen by vector_prefix_bit
// - Faulting load multiple or string may have written some registers
// - Faulting store multiple or string may write bytes, never protected ones
// - Direct-store locations of an unsupported partial access are never touched
// - Update forms keep base_address_reg unchanged on the data fault
// - Cause goes into syndrome flag bits, address into fault_address_reg
`ifndef DFU_CONSTS_SVH
`define DFU_CONSTS_SVH

`define DFU_OFF_SYNDROME 8'h00
`define DFU_OFF_FAULT_ADDR 8'h04
`define DFU_OFF_MACHINE_STATE 8'h08
`define DFU_OFF_IRQ_STATUS 8'h0C
`define DFU_OFF_IRQ_MASK 8'h10

// Syndrome flags, as bit positions counted up from the least significant bit
`define DFU_SYN_NOTRANS 30
`define DFU_SYN_PROT 27
`define DFU_SYN_DSTORE 26
`define DFU_SYN_STORE 25

`define DFU_MSR_PREFIX 0
`define DFU_IRQ_DSI 0
`define DFU_IRQ_MISS 1

`define DFU_RST_SYNDROME 32'h0000_0000
`define DFU_RST_FAULT_ADDR 32'h0000_0000
`define DFU_RST_PREFIX 1'h0
`define DFU_RST_IRQ 2'h0

`define DFU_VEC_OFFSET 32'h0000_0300
`define DFU_VEC_HIGH_BASE 32'hFFF0_0000
`define DFU_VEC_LOW_BASE 32'h0000_0000

`endif

// *** rtl/dfu_pkg.sv ***
/*
 * Types shared by the data access fault unit.
 * Assumes a single clock domain; no constants live here.
 */
package dfu_pkg;

    typedef enum logic [2:0] {
        DFU_OP_LOAD,
        DFU_OP_STORE,
        DFU_OP_DC_INVAL,
        DFU_OP_DC_ZERO,
        DFU_OP_DC_STORE,
        DFU_OP_DC_FLUSH,
        DFU_OP_OTHER
    } dfu_op_t;

    // Translation view of one page touched by the access
    typedef struct packed {
        logic direct_store_flag;
        logic miss;
        logic block_hit;
        logic [1:0] block_prot;
        logic supervisor_key;
        logic user_key;
        logic [1:0] page_protection_field;
    } dfu_page_t;

    typedef struct packed {
        dfu_op_t op;
        logic [31:0] ea;
        logic [31:0] ea_second;
        logic crosses_page;
        logic problem_state;
        logic multi_or_string;
        logic str_imm_zero;
        logic cond_store;
        logic update_form;
        logic mem_unsupported;
        logic bus_err_dstore;
    } dfu_req_t;

endpackage : dfu_pkg

// *** rtl/dfu_page_check.sv ***
/*
 * Fault check of one page of a data access: protection and direct-store.
 * Assumes page attributes come from the translation units in the same cycle.
 */
`timescale 1ns/10ps
`default_nettype none
module dfu_page_check #(
    parameter int PP_W = 2
) (
    input wire dfu_pkg::dfu_page_t page,
    input wire logic is_store,
    input wire logic problem_state,
    input wire logic used,
    output logic prot_fault,
    output logic dstore_fault,
    output logic miss
);
    logic key;
    logic no_access;
    logic read_only;

    always_comb begin
        key = problem_state ? page.user_key : page.supervisor_key;
        if (page.block_hit) begin
            no_access = (page.block_prot == PP_W'(0));
            read_only = page.block_prot[0];
        end else if (key) begin
            no_access = (page.page_protection_field == PP_W'(0));
            read_only = (page.page_protection_field != PP_W'(2));
        end else begin
            no_access = 1'b0;
            read_only = (page.page_protection_field == PP_W'(3));
        end
    end

    // Direct-store segments fault before any protection or miss is looked at
    assign dstore_fault = used & page.direct_store_flag;
    // A block hit translates the access even when the page table has no entry
    assign prot_fault = used & ~page.direct_store_flag & (page.block_hit | ~page.miss)
                        & (no_access | (is_store & read_only));
    assign miss = used & ~page.direct_store_flag & page.miss & ~page.block_hit;
endmodule : dfu_page_check
`default_nettype wire

// *** verif/test_data_access_fault_unit.sv ***
/*
 * Self-checking bench of the data access fault unit: one task per scenario.
 * Assumes the rtl/ package, header and modules are compiled before it.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dfu_consts.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module test_data_access_fault_unit;
    logic clk_sys;
    logic rstn;
    logic acc_valid;
    dfu_pkg::dfu_req_t acc_req;
    dfu_pkg::dfu_page_t page_first;
    dfu_pkg::dfu_page_t page_second;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic dsi_take;
    logic miss_take;
    logic [31:0] vec_addr;
    logic [1:0] page_access;
    logic [1:0] regs_wb;
    logic resv_check;
    logic base_update;
    logic irq;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    dfu_pkg::dfu_page_t ok_pg;
    dfu_pkg::dfu_page_t ds_pg;
    dfu_pkg::dfu_page_t ro_pg;
    dfu_pkg::dfu_req_t r;

    dfu_fault_unit #(.PAGE_BITS(12)) DUT (.clk_sys(clk_sys), .rstn(rstn), .acc_valid(acc_valid),
        .acc_req(acc_req), .page_first(page_first), .page_second(page_second), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .dsi_take(dsi_take), .miss_take(miss_take), .vec_addr(vec_addr), .page_access(page_access),
        .regs_wb(regs_wb), .resv_check(resv_check), .base_update(base_update), .irq(irq));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] syn(input int b);
        return 32'h0000_0001 << b;
    endfunction : syn

    function automatic dfu_pkg::dfu_req_t mk(input dfu_pkg::dfu_op_t op);
        dfu_pkg::dfu_req_t q;
        q = '0;
        q.op = op;
        q.ea = 32'h0000_1FFE;
        q.ea_second = 32'h0000_2001;
        return q;
    endfunction : mk

    task automatic acc(input dfu_pkg::dfu_req_t q, input dfu_pkg::dfu_page_t p0, input dfu_pkg::dfu_page_t p1);
        @(posedge clk_sys);
        acc_valid <= 1'b1;
        acc_req <= q;
        page_first <= p0;
        page_second <= p1;
        @(posedge clk_sys);
        acc_valid <= 1'b0;
        #1;
    endtask : acc

    task automatic outs(input logic dsi, input logic miss, input logic [1:0] pa);
        `CHK(dsi_take, dsi)
        `CHK(miss_take, miss)
        `CHK(page_access, pa)
    endtask : outs

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask : rd

    task automatic t_reset;
        rd(`DFU_OFF_SYNDROME, `DFU_RST_SYNDROME);
        rd(`DFU_OFF_FAULT_ADDR, `DFU_RST_FAULT_ADDR);
        rd(`DFU_OFF_MACHINE_STATE, 32'h0000_0000);
        rd(`DFU_OFF_IRQ_MASK, 32'h0000_0000);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_causes;
        acc(mk(dfu_pkg::DFU_OP_LOAD), ds_pg, ok_pg);
        outs(1'b1, 1'b0, 2'b00);
        `CHK(vec_addr, `DFU_VEC_LOW_BASE | `DFU_VEC_OFFSET)
        rd(`DFU_OFF_SYNDROME, syn(`DFU_SYN_DSTORE));
        rd(`DFU_OFF_FAULT_ADDR, 32'h0000_1FFE);
        r = mk(dfu_pkg::DFU_OP_LOAD);
        r.mem_unsupported = 1'b1;
        acc(r, ok_pg, ok_pg);
        outs(1'b1, 1'b0, 2'b00);
        r = mk(dfu_pkg::DFU_OP_STORE);
        r.bus_err_dstore = 1'b1;
        acc(r, ok_pg, ok_pg);
        outs(1'b1, 1'b0, 2'b00);
        acc(mk(dfu_pkg::DFU_OP_LOAD), ro_pg, ok_pg);
        outs(1'b0, 1'b0, 2'b01);
        acc(mk(dfu_pkg::DFU_OP_STORE), ro_pg, ok_pg);
        outs(1'b1, 1'b0, 2'b00);
        rd(`DFU_OFF_SYNDROME, syn(`DFU_SYN_PROT) | syn(`DFU_SYN_STORE));
        r = mk(dfu_pkg::DFU_OP_LOAD);
        r.problem_state = 1'b1;
        acc(r, '{user_key: 1'b1, default: '0}, ok_pg);
        outs(1'b1, 1'b0, 2'b00);
        acc(mk(dfu_pkg::DFU_OP_LOAD), '{block_hit: 1'b1, default: '0}, ok_pg);
        outs(1'b1, 1'b0, 2'b00);
        acc(mk(dfu_pkg::DFU_OP_LOAD), '{block_hit: 1'b1, miss: 1'b1, default: '0}, ok_pg);
        outs(1'b1, 1'b0, 2'b00);
        for (int i = 2; i < 6; i++) begin
            acc(mk(dfu_pkg::dfu_op_t'(i)), ds_pg, ok_pg);
            `CHK(dsi_take, 1'b1)
        end
        acc(mk(dfu_pkg::DFU_OP_OTHER), ds_pg, ok_pg);
        `CHK(dsi_take, 1'b0)
        acc(mk(dfu_pkg::DFU_OP_LOAD), '{miss: 1'b1, default: '0}, ok_pg);
        outs(1'b0, 1'b1, 2'b00);
        $display("test causes done");
    endtask : t_causes

    task automatic t_cross;
        r = mk(dfu_pkg::DFU_OP_LOAD);
        r.crosses_page = 1'b1;
        acc(r, ok_pg, ok_pg);
        outs(1'b0, 1'b0, 2'b11);
        acc(r, ok_pg, ds_pg);
        `CHK(dsi_take, 1'b1)
        rd(`DFU_OFF_FAULT_ADDR, 32'h0000_2000);
        r.multi_or_string = 1'b1;
        acc(r, ok_pg, ro_pg);
        outs(1'b0, 1'b0, 2'b11);
        `CHK(regs_wb, 2'b11)
        r.op = dfu_pkg::DFU_OP_STORE;
        acc(r, ok_pg, ro_pg);
        outs(1'b1, 1'b0, 2'b01);
        acc(r, ok_pg, ds_pg);
        outs(1'b1, 1'b0, 2'b01);
        r.op = dfu_pkg::DFU_OP_LOAD;
        acc(r, ok_pg, '{miss: 1'b1, default: '0});
        outs(1'b0, 1'b1, 2'b01);
        `CHK(regs_wb, 2'b01)
        $display("test cross done");
    endtask : t_cross

    task automatic t_side;
        r = mk(dfu_pkg::DFU_OP_STORE);
        r.cond_store = 1'b1;
        acc(r, ok_pg, ok_pg);
        `CHK(resv_check, 1'b1)
        acc(r, ds_pg, ok_pg);
        `CHK(resv_check, 1'b0)
        `CHK(dsi_take, 1'b1)
        r = mk(dfu_pkg::DFU_OP_LOAD);
        r.update_form = 1'b1;
        acc(r, ok_pg, ok_pg);
        `CHK(base_update, 1'b1)
        acc(r, ds_pg, ok_pg);
        `CHK(base_update, 1'b0)
        r = mk(dfu_pkg::DFU_OP_STORE);
        r.str_imm_zero = 1'b1;
        acc(r, ds_pg, ds_pg);
        outs(1'b0, 1'b0, 2'b00);
        $display("test side effects done");
    endtask : t_side

    task automatic t_vec_irq;
        wr(`DFU_OFF_MACHINE_STATE, 32'h0000_0001);
        rd(`DFU_OFF_MACHINE_STATE, 32'h0000_0001);
        wr(`DFU_OFF_IRQ_STATUS, 32'h0000_0003);
        acc(mk(dfu_pkg::DFU_OP_LOAD), ds_pg, ok_pg);
        `CHK(vec_addr, `DFU_VEC_HIGH_BASE | `DFU_VEC_OFFSET)
        rd(`DFU_OFF_IRQ_STATUS, 32'h0000_0001);
        `CHK(irq, 1'b0)
        wr(`DFU_OFF_IRQ_MASK, 32'h0000_0001);
        rd(`DFU_OFF_IRQ_MASK, 32'h0000_0001);
        `CHK(irq, 1'b1)
        wr(`DFU_OFF_IRQ_STATUS, 32'h0000_0001);
        rd(`DFU_OFF_IRQ_STATUS, 32'h0000_0000);
        `CHK(irq, 1'b0)
        acc(mk(dfu_pkg::DFU_OP_LOAD), '{miss: 1'b1, default: '0}, ok_pg);
        rd(`DFU_OFF_IRQ_STATUS, 32'h0000_0002);
        `CHK(irq, 1'b0)
        wr(`DFU_OFF_SYNDROME, 32'h0000_0055);
        rd(`DFU_OFF_SYNDROME, 32'h0000_0055);
        $display("test vector and interrupt done");
    endtask : t_vec_irq

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    // Ceiling well above the roughly 110 cycles the scenarios need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 5000) begin
            fail_count++;
            wrap_up();
        end
    end

    initial begin
        ok_pg = '0;
        ds_pg = '{direct_store_flag: 1'b1, default: '0};
        ro_pg = '{page_protection_field: 2'h3, default: '0};
        rstn = 1'b0;
        acc_valid = 1'b0;
        acc_req = '0;
        page_first = '0;
        page_second = '0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_causes();
        t_cross();
        t_side();
        t_vec_irq();
        wrap_up();
    end
endmodule : test_data_access_fault_unit
`default_nettype wire
